// File: pfc_core.sv
`timescale 1ns/1ps
`default_nettype none
`include "pfc_map.svh"

module pfc_core import pfc_pkg::*; (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  // Software configuration and writes
  input wire pfc_cfg_t cfg_i,
  input wire pfc_wr_t wr_i,
  // General-purpose port path
  input wire logic [`PFC_NCH-1:0] gpio_dir_i,
  input wire logic [`PFC_NCH-1:0] gpio_data_i,
  // Shared pins and readback
  output logic [`PFC_NCH-1:0] pin_out_o,
  output logic [`PFC_NCH-1:0] pin_oe_o,
  output logic [`PFC_NCH-1:0][`PFC_CW-1:0] cnt_o
);

  logic rst_meta_r;
  logic rst_n;
  logic [3:0] tick;
  logic [1:0] join_w;
  logic [`PFC_NCH-1:0][`PFC_CW-1:0] cnt_r;
  logic [`PFC_NCH-1:0][`PFC_CW-1:0] per_buf_r;
  logic [`PFC_NCH-1:0][`PFC_CW-1:0] duty_buf_r;
  logic [`PFC_NCH-1:0][`PFC_CW-1:0] per_act_r;
  logic [`PFC_NCH-1:0][`PFC_CW-1:0] duty_act_r;
  logic [`PFC_NCH-1:0] up_r;
  logic [`PFC_NCH-1:0] out_r;
  logic [`PFC_NCH-1:0] pin_out_r;
  logic [`PFC_NCH-1:0] pin_oe_r;
  logic [`PFC_NCH-1:0][`PFC_CW-1:0] cnt_nxt;
  logic [`PFC_NCH-1:0] up_nxt;
  logic [`PFC_NCH-1:0] out_nxt;
  logic [`PFC_NCH-1:0] en_eff;
  logic [`PFC_NCH-1:0] lane_join;
  logic [`PFC_NCH-1:0] tick_w;
  logic [`PFC_NCH-1:0] roll_w;
  logic [`PFC_NCH-1:0] own_w;
  logic [`PFC_NCH-1:0] cnt_hit;
  logic [`PFC_NCH-1:0] per_hit;
  logic [`PFC_NCH-1:0] duty_hit;

  // Reset release through two flops
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_meta_r <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n <= rst_meta_r;
    end
  end

  // Shared prescaler: clocks A, B and scaled S0, S1
  pfc_prescale u_prescale (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n),
    .run_i(|cfg_i.channel_enable),
    .sel_first_i(cfg_i.prescale_sel_first),
    .sel_second_i(cfg_i.prescale_sel_second),
    .scale_first_i(cfg_i.scale_first),
    .scale_second_i(cfg_i.scale_second),
    .tick_o(tick)
  );

  // One step of a left or center counter, 8 or 16 bits wide
  function automatic pfc_step_t pfc_step(input logic [`PFC_WW-1:0] cnt,
                                         input logic [`PFC_WW-1:0] per,
                                         input logic ctr,
                                         input logic up);
    pfc_step_t s;
    logic [`PFC_WW-1:0] last;
    s.cnt = cnt;
    s.up = up;
    s.roll = 1'b0;
    last = (per == 16'h0000) ? 16'h0000 : per - 16'h0001;
    if (!ctr) begin
      s.up = 1'b1;
      if (cnt >= last) begin
        s.cnt = 16'h0000;
        s.roll = 1'b1;
      end else begin
        s.cnt = cnt + 16'h0001;
      end
    end else if (up) begin
      if (cnt + 16'h0001 >= per) begin
        s.cnt = per;
        s.up = 1'b0;
      end else begin
        s.cnt = cnt + 16'h0001;
      end
    end else if (cnt <= 16'h0001) begin
      s.cnt = 16'h0000;
      s.up = 1'b1;
      s.roll = 1'b1;
    end else begin
      s.cnt = cnt - 16'h0001;
    end
    return s;
  endfunction

  assign join_w = {cfg_i.join_pair_high, cfg_i.join_pair_low};

  // Lane steering: joined pairs run as one 16-bit counter
  always_comb begin
    pfc_step_t st;
    logic [`PFC_WW-1:0] c16;
    logic [`PFC_WW-1:0] d16;
    int ev;
    int sl;
    st = '0;
    c16 = 16'h0000;
    d16 = 16'h0000;
    ev = 0;
    sl = 0;
    for (int c = 0; c < `PFC_NCH; c++) begin
      ev = c & 2;
      lane_join[c] = join_w[c/2];
      sl = lane_join[c] ? ev + 1 : c;
      en_eff[c] = cfg_i.channel_enable[lane_join[c] ? ev : c];
      if (c < 2) begin
        tick_w[c] = cfg_i.clk_sel[sl] ? tick[2] : tick[0];
      end else begin
        tick_w[c] = cfg_i.clk_sel[sl] ? tick[3] : tick[1];
      end
      if (lane_join[c]) begin
        c16 = {cnt_r[ev], cnt_r[ev+1]};
        d16 = {duty_act_r[ev], duty_act_r[ev+1]};
        st = pfc_step(c16, {per_act_r[ev], per_act_r[ev+1]},
                      cfg_i.center_align[ev], up_r[ev]);
        cnt_nxt[c] = (c == ev) ? st.cnt[15:8] : st.cnt[7:0];
      end else begin
        c16 = {8'h00, cnt_r[c]};
        d16 = {8'h00, duty_act_r[c]};
        st = pfc_step(c16, {8'h00, per_act_r[c]},
                      cfg_i.center_align[c], up_r[c]);
        cnt_nxt[c] = st.cnt[7:0];
      end
      up_nxt[c] = st.up;
      roll_w[c] = tick_w[c] & st.roll;
      // Duty 0 or past period gives 0 or 100 percent
      out_nxt[c] = cfg_i.output_polarity[lane_join[c] ? ev : c]
                   ? (c16 < d16) : !(c16 < d16);
      own_w[c] = en_eff[c] & !(lane_join[c] & (c != ev));
      per_hit[c] = wr_i.per_we & (wr_i.ch == 2'(c));
      duty_hit[c] = wr_i.duty_we & (wr_i.ch == 2'(c));
      cnt_hit[c] = wr_i.cnt_we & ((wr_i.ch == 2'(c)) |
                   (lane_join[c] & (wr_i.ch[1] == 1'(c/2))));
    end
  end

  // Buffered period and duty
  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      per_buf_r <= '0;
      duty_buf_r <= '0;
    end else begin
      for (int c = 0; c < `PFC_NCH; c++) begin
        if (per_hit[c]) begin
          per_buf_r[c] <= wr_i.data;
        end
        if (duty_hit[c]) begin
          duty_buf_r[c] <= wr_i.data;
        end
      end
    end
  end

  // Active latches: direct when idle, else at rollover or counter write
  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      per_act_r <= '0;
      duty_act_r <= '0;
    end else begin
      for (int c = 0; c < `PFC_NCH; c++) begin
        if (!en_eff[c] || cnt_hit[c] || roll_w[c]) begin
          per_act_r[c] <= per_hit[c] ? wr_i.data : per_buf_r[c];
          duty_act_r[c] <= duty_hit[c] ? wr_i.data : duty_buf_r[c];
        end
      end
    end
  end

  // Counters; a counter write beats a tick
  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= {`PFC_NCH{`PFC_CNT_RST}};
      up_r <= '1;
    end else begin
      for (int c = 0; c < `PFC_NCH; c++) begin
        if (!en_eff[c] || cnt_hit[c]) begin
          cnt_r[c] <= `PFC_CNT_RST;
          up_r[c] <= 1'b1;
        end else if (tick_w[c]) begin
          cnt_r[c] <= cnt_nxt[c];
          up_r[c] <= up_nxt[c];
        end
      end
    end
  end

  // Waveform moves only on a source tick while enabled (disable clears it at once), so enable lands on one
  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      out_r <= '0;
    end else begin
      for (int c = 0; c < `PFC_NCH; c++) begin
        if (!en_eff[c]) begin
          out_r[c] <= 1'b0;
        end else if (tick_w[c]) begin
          out_r[c] <= out_nxt[c];
        end
      end
    end
  end

  // Pin mux; the direction input itself is never touched
  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      pin_out_r <= '0;
      pin_oe_r <= '0;
    end else begin
      for (int c = 0; c < `PFC_NCH; c++) begin
        pin_oe_r[c] <= own_w[c] | gpio_dir_i[c];
        pin_out_r[c] <= own_w[c] ? out_r[c] : gpio_data_i[c];
      end
    end
  end

  assign pin_out_o = pin_out_r;
  assign pin_oe_o = pin_oe_r;
  assign cnt_o = cnt_r;

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n);

  property p_idle_clear;
    !en_eff[0] |=> cnt_r[0] == 8'h00;
  endproperty
  a_idle_clear: assert property (p_idle_clear)
    else $error("Disabled channel 0 counter not cleared");

  property p_cnt_write;
    wr_i.cnt_we && wr_i.ch == 2'h0 |=> cnt_r[0] == 8'h00 &&
      per_act_r[0] == $past(per_hit[0] ? wr_i.data : per_buf_r[0]) &&
      duty_act_r[0] == $past(duty_hit[0] ? wr_i.data : duty_buf_r[0]);
  endproperty
  a_cnt_write: assert property (p_cnt_write)
    else $error("Counter write did not clear and load");

  property p_hold_buf;
    en_eff[0] && !roll_w[0] && !cnt_hit[0] ##1 en_eff[0]
      |-> $stable(per_act_r[0]) && $stable(duty_act_r[0]);
  endproperty
  a_hold_buf: assert property (p_hold_buf)
    else $error("Active values changed without rollover");

  property p_roll_load;
    en_eff[0] && roll_w[0] && !cnt_hit[0] |=>
      duty_act_r[0] == $past(duty_hit[0] ? wr_i.data : duty_buf_r[0]);
  endproperty
  a_roll_load: assert property (p_roll_load)
    else $error("Rollover did not load pending duty");

  property p_idle_direct;
    !en_eff[2] && per_hit[2] |=> per_act_r[2] == $past(wr_i.data);
  endproperty
  a_idle_direct: assert property (p_idle_direct)
    else $error("Idle period write missed active latch");

  sequence s_enable_held;
    cfg_i.channel_enable[0] && !join_w[0] ##1 1'b1;
  endsequence

  property p_pin_own;
    s_enable_held |-> pin_oe_o[0];
  endproperty
  a_pin_own: assert property (p_pin_own)
    else $error("Enabled channel 0 pin not driven");

  property p_join_free;
    join_w[0] && !gpio_dir_i[1] |=> !pin_oe_o[1];
  endproperty
  a_join_free: assert property (p_join_free)
    else $error("Joined odd pin still driven");

  property p_zero_duty;
    en_eff[0] && tick_w[0] && cfg_i.output_polarity[0] && !lane_join[0]
      && duty_act_r[0] == 8'h00 |=> !out_r[0];
  endproperty
  a_zero_duty: assert property (p_zero_duty)
    else $error("Zero duty produced an active level");

  property p_no_tick_hold;
    en_eff[1] && !tick_w[1] && !cnt_hit[1] ##1 en_eff[1]
      |-> $stable(cnt_r[1]) && $stable(out_r[1]);
  endproperty
  a_no_tick_hold: assert property (p_no_tick_hold)
    else $error("Channel 1 moved without a source tick");

endmodule // pfc_core

`default_nettype wire

// File: pfc_map.svh
`ifndef PFC_MAP_SVH
`define PFC_MAP_SVH

// Channel count and widths
`define PFC_NCH 4
`define PFC_CW 8
`define PFC_WW 16
`define PFC_PRES_W 7
`define PFC_DIV_W 3
`define PFC_SCALE_W 8

// Reset values
`define PFC_CNT_RST 8'h00
`define PFC_PRES_RST 7'h00
`define PFC_SCALE_RST 8'h00

`endif

// File: pfc_pkg.sv
`default_nettype none
`include "pfc_map.svh"

package pfc_pkg;

  // Software configuration bits, all same clock domain
  typedef struct packed {
    logic join_pair_high;
    logic join_pair_low;
    logic [`PFC_DIV_W-1:0] prescale_sel_first;
    logic [`PFC_DIV_W-1:0] prescale_sel_second;
    logic [`PFC_NCH-1:0] clk_sel;
    logic [`PFC_NCH-1:0] output_polarity;
    logic [`PFC_NCH-1:0] center_align;
    logic [`PFC_NCH-1:0] channel_enable;
    logic [`PFC_SCALE_W-1:0] scale_first;
    logic [`PFC_SCALE_W-1:0] scale_second;
  } pfc_cfg_t;

  // One-cycle software write strobe with its data
  typedef struct packed {
    logic per_we;
    logic duty_we;
    logic cnt_we;
    logic [1:0] ch;
    logic [`PFC_CW-1:0] data;
  } pfc_wr_t;

  // Result of one counter step
  typedef struct packed {
    logic [`PFC_WW-1:0] cnt;
    logic up;
    logic roll;
  } pfc_step_t;

endpackage

`default_nettype wire

// File: pfc_prescale.sv
`timescale 1ns/1ps
`default_nettype none
`include "pfc_map.svh"

module pfc_prescale import pfc_pkg::*; (
  // Clock and synchronised reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // Control
  input wire logic run_i,
  input wire logic [`PFC_DIV_W-1:0] sel_first_i,
  input wire logic [`PFC_DIV_W-1:0] sel_second_i,
  input wire logic [`PFC_SCALE_W-1:0] scale_first_i,
  input wire logic [`PFC_SCALE_W-1:0] scale_second_i,
  // Ticks: A, B, S0, S1
  output logic [3:0] tick_o
);

  logic [`PFC_PRES_W-1:0] pres_r;
  logic [1:0] tick_ab_r;
  logic [1:0] tick_s_r;
  logic [1:0][`PFC_SCALE_W-1:0] sc_cnt_r;
  logic [1:0] half_r;
  logic [1:0][`PFC_SCALE_W-1:0] scale_w;

  // Tick when the low sel bits of the prescaler are all ones
  function automatic logic div_tick(input logic [`PFC_PRES_W-1:0] p,
                                    input logic [`PFC_DIV_W-1:0] s);
    logic [`PFC_PRES_W-1:0] m;
    m = `PFC_PRES_W'((8'h01 << s) - 8'h01);
    return (p & m) == m;
  endfunction

  assign scale_w = {scale_second_i, scale_first_i};
  assign tick_o = {tick_s_r, tick_ab_r};

  // Stopped while no channel runs, to save power
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pres_r <= `PFC_PRES_RST;
    end else if (!run_i) begin
      pres_r <= `PFC_PRES_RST;
    end else begin
      pres_r <= pres_r + `PFC_PRES_W'(1);
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tick_ab_r <= 2'h0;
    end else begin
      tick_ab_r[0] <= run_i & div_tick(pres_r, sel_first_i);
      tick_ab_r[1] <= run_i & div_tick(pres_r, sel_second_i);
    end
  end

  // Scaled clocks: one tick per 2*scale source ticks, scale 0 means 256
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sc_cnt_r <= {2{`PFC_SCALE_RST}};
      half_r <= 2'h0;
      tick_s_r <= 2'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        tick_s_r[i] <= 1'b0;
        if (!run_i) begin
          sc_cnt_r[i] <= `PFC_SCALE_RST;
          half_r[i] <= 1'b0;
        end else if (tick_ab_r[i]) begin
          if (sc_cnt_r[i] == scale_w[i] - `PFC_SCALE_W'(1)) begin
            sc_cnt_r[i] <= `PFC_SCALE_RST;
            half_r[i] <= ~half_r[i];
            tick_s_r[i] <= half_r[i];
          end else begin
            sc_cnt_r[i] <= sc_cnt_r[i] + `PFC_SCALE_W'(1);
          end
        end
      end
    end
  end

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_half_rate;
    (run_i && sel_first_i == 3'h1)[*3];
  endsequence

  property p_div_two;
    (s_half_rate and (tick_ab_r[0] ##1 !tick_ab_r[0] ##1 1'b1))
      |-> tick_ab_r[0];
  endproperty
  a_div_two: assert property (p_div_two)
    else $error("Clock A at divide by two lost its rhythm");

  property p_stop_quiet;
    !run_i |=> (tick_ab_r == 2'h0) && (pres_r == `PFC_PRES_RST);
  endproperty
  a_stop_quiet: assert property (p_stop_quiet)
    else $error("Prescaler ticked while stopped");

endmodule // pfc_prescale

`default_nettype wire

// File: pfc_top_note_unused.sv
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// File: pfc_core_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "pfc_map.svh"

module pfc_core_bench import pfc_pkg::*; ;
  logic sys_clk_i;
  logic nrst_i;
  pfc_cfg_t cfg;
  pfc_wr_t wr;
  logic [`PFC_NCH-1:0] gdir;
  logic [`PFC_NCH-1:0] gdat;
  logic [`PFC_NCH-1:0] pin_out;
  logic [`PFC_NCH-1:0] pin_oe;
  logic [`PFC_NCH-1:0][`PFC_CW-1:0] cnt;
  int error_cnt;
  int checked;
  int n;
  int h;
  int pol[4] = '{1, 0, 1, 1};
  int dty[4] = '{1, 1, 0, 5};
  int hig[4] = '{10, 30, 0, 40};

  pfc_core pfc_core_inst (
    .sys_clk_i(sys_clk_i),
    .nrst_i(nrst_i),
    .cfg_i(cfg),
    .wr_i(wr),
    .gpio_dir_i(gdir),
    .gpio_data_i(gdat),
    .pin_out_o(pin_out),
    .pin_oe_o(pin_oe),
    .cnt_o(cnt)
  );

  initial begin
    sys_clk_i = 1'b0;
    forever #50 sys_clk_i = ~sys_clk_i;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(negedge sys_clk_i);
  endtask

  // Strobe order: period, duty, counter
  task automatic put(input logic [2:0] we, input logic [1:0] ch,
                     input logic [7:0] d);
    @(negedge sys_clk_i);
    wr = {we, ch, d};
    @(negedge sys_clk_i);
    wr = '0;
  endtask

  task automatic setch(input logic [1:0] ch, input logic [7:0] p,
                       input logic [7:0] d);
    put(3'b100, ch, p);
    put(3'b010, ch, d);
  endtask

  task automatic hi(input int ch, input int k, output int c);
    c = 0;
    repeat (k) begin
      @(negedge sys_clk_i);
      if (pin_out[ch] === 1'b1) c++;
    end
  endtask

  // Counter steps seen in a window; window is a whole number of ticks
  task automatic steps(input int ch, input int k, output int s);
    logic [7:0] last;
    s = 0;
    last = cnt[ch];
    repeat (k) begin
      @(negedge sys_clk_i);
      if (cnt[ch] !== last) s++;
      last = cnt[ch];
    end
  endtask

  task automatic upto(input int ch, input logic [7:0] v);
    int i;
    i = 0;
    while (cnt[ch] !== v && i < 1000) begin
      @(negedge sys_clk_i);
      i++;
    end
    chk(cnt[ch], v);
  endtask

  task automatic final_report();
    $display("checks=%0d errors=%0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Whole run is near 5000 cycles
  initial begin
    #2000000;
    error_cnt++;
    final_report();
  end

  initial begin
    nrst_i = 1'b0;
    cfg = '0;
    wr = '0;
    gdir = 4'h0;
    gdat = 4'hF;
    error_cnt = 0;
    checked = 0;
    cyc(12);
    chk({pin_oe, pin_out, cnt}, 40'h0);
    nrst_i = 1'b1;
    cyc(3);
    // Unowned pins follow the port data once reset is gone
    chk({pin_oe, pin_out, cnt}, 40'h0F00000000);
    gdir = 4'hA;
    cyc(2);
    chk(pin_oe, 4'hA);
    $display("test reset done");

    for (n = 0; n < 4; n++) begin
      cfg.channel_enable = 4'h0;
      cfg.output_polarity = pol[n][3:0];
      setch(2'h0, 8'h04, dty[n][7:0]);
      cfg.channel_enable = 4'h1;
      cyc(8);
      hi(0, 40, h);
      chk(h, hig[n]);
    end
    chk(pin_oe, 4'hB);
    $display("test duty done");

    cfg.channel_enable = 4'h0;
    cfg.output_polarity = 4'h1;
    setch(2'h0, 8'hC8, 8'h64);
    cfg.channel_enable = 4'h1;
    upto(0, 8'h0A);
    put(3'b010, 2'h0, 8'h32);
    upto(0, 8'h46);
    chk(pin_out[0], 1'b1);
    upto(0, 8'h05);
    upto(0, 8'h46);
    chk(pin_out[0], 1'b0);
    put(3'b011, 2'h0, 8'h96);
    chk(cnt[0], 8'h00);
    upto(0, 8'h78);
    chk(pin_out[0], 1'b1);
    cyc(1);
    chk(cnt[0], 8'h79);
    $display("test buffer done");

    // Phase of the free prescaler does not matter over 256 cycles
    cfg.channel_enable = 4'h0;
    setch(2'h0, 8'hFF, 8'h00);
    setch(2'h2, 8'hFF, 8'h00);
    cfg.channel_enable = 4'h5;
    for (n = 0; n < 8; n++) begin
      cfg.prescale_sel_first = n[2:0];
      cyc(4);
      steps(0, 256, h);
      chk(h, 256 >> n);
    end
    cfg.prescale_sel_first = 3'h0;
    cfg.prescale_sel_second = 3'h1;
    cfg.scale_first = 8'h02;
    cfg.scale_second = 8'h04;
    cyc(4);
    steps(2, 256, h);
    chk(h, 128);
    cfg.clk_sel = 4'h5;
    cyc(40);
    steps(0, 256, h);
    chk(h, 64);
    steps(2, 256, h);
    chk(h, 16);
    $display("test clocks done");

    cfg.channel_enable = 4'h0;
    cfg.prescale_sel_second = 3'h0;
    cfg.clk_sel = 4'h0;
    cfg.center_align = 4'h4;
    cfg.output_polarity = 4'h4;
    setch(2'h2, 8'h04, 8'h02);
    cfg.channel_enable = 4'h4;
    cyc(8);
    hi(2, 80, h);
    chk(h, 30);
    $display("test center done");

    cfg.channel_enable = 4'h0;
    cfg.center_align = 4'h0;
    cfg.output_polarity = 4'h1;
    cfg.join_pair_low = 1'b1;
    gdir = 4'h0;
    setch(2'h0, 8'h01, 8'h00);
    setch(2'h1, 8'h04, 8'h41);
    cfg.channel_enable = 4'h1;
    cyc(8);
    hi(0, 1040, h);
    chk(h, 260);
    chk(pin_oe, 4'h1);
    $display("test join done");

    nrst_i = 1'b0;
    cyc(2);
    chk({pin_oe, pin_out, cnt}, 40'h0);
    $display("test rerun reset done");
    final_report();
  end
endmodule // pfc_core_bench

`default_nettype wire
